//--- testbench/altmode_failure_notice_sequencer_test.sv
// Self-checking bench of the alternate-mode failure notice sequencer
`timescale 1ns/1ns
`default_nettype none
module altmode_failure_notice_sequencer_test;
    import notice_pkg::*;
    // Short tick and hold keep the run brief
    localparam int TK = 10;
    localparam int HD = 4;
    localparam int HDLY = 3;
    logic clk, rst, read, write, waitrequest;
    logic [15:0] address;
    logic [31:0] writedata, readdata, q;
    logic [16:0] pinIn;
    logic [4:0] pdIdx;
    logic addressAssigned, altStringRequested, portAttach;
    logic noticeDescriptors, pdPin, failCmd, askString;
    logic [1:0] configuredStatus;
    int err_count, samples_checked, cycles, n;

    altmode_failure_notice_sequencer #(.TICK(TK), .HOLD(HD)) DUT (
        .clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .pinIn(pinIn),
        .addressAssigned(addressAssigned),
        .altStringRequested(altStringRequested), .portAttach(portAttach),
        .noticeDescriptors(noticeDescriptors),
        .configuredStatus(configuredStatus));

    pd_host_model #(.HOST_DELAY(HDLY)) partner (
        .clk(clk), .rst(rst), .failCmd(failCmd), .askString(askString),
        .portAttach(portAttach), .noticeDescriptors(noticeDescriptors),
        .pdPin(pdPin), .addressAssigned(addressAssigned),
        .altStringRequested(altStringRequested));

    // Unselected pins idle high so only the chosen one can trigger
    always_comb begin
        pinIn = '1;
        pinIn[pdIdx] = pdPin;
    end

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic chk_val(input logic [31:0] got, exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, lo, hi, input string what);
        samples_checked++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("[FAIL] %0t %s took %0d cycles", $time, what, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("[FAIL] %0t run did not finish", $time);
            close_out();
        end
    end

    // ****************************************
    // Bus cycles and waits
    // ****************************************
    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [15:0] a,
                       input logic [7:0] d, output logic [31:0] r);
        int k;
        k = 0;
        @(posedge clk);
        address <= a;
        writedata <= {24'h000000, d};
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        r = readdata;
        write <= 1'b0;
        read <= 1'b0;
        chk_cnt(k, 1, 49, "bus answer");
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00, q);
        chk_val(q, e, "read back");
    endtask

    task automatic wait_attach(input logic lvl, input int lim);
        n = 0;
        while (portAttach !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask

    // Drop, notice, timer expiry, drop, standard: v is the timer value
    task automatic notice_cycle(input int v, input string what);
        @(posedge clk);
        failCmd <= 1'b1;
        wait_attach(1'b0, 20);
        chk_cnt(n, 1, 5, "detach on low pin");
        wait_attach(1'b1, 50);
        chk_cnt(n, HD, HD, "first drop length");
        chk_val(noticeDescriptors, 1'b1, "notice descriptors");
        chk_val(configuredStatus, CFG_UNSPECIFIED, "configured status");
        wait_attach(1'b0, 5000);
        chk_cnt(n, v * TK + HDLY - 1, v * TK + HDLY + 5, what);
        wait_attach(1'b1, 50);
        chk_cnt(n, HD, HD, "second drop length");
        @(posedge clk);
        chk_val(noticeDescriptors, 1'b0, "standard descriptors");
        failCmd <= 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_regs();
        rd(IDX_TIMER_A_LOW, 32'h000000D0);
        rd(IDX_TIMER_A_HIGH, 32'h00000007);
        rd(IDX_TIMER_B_LOW, 32'h000000D0);
        rd(IDX_TIMER_B_HIGH, 32'h00000007);
        rd(IDX_NOTICE_CONTROL, 32'h00000014);
        wr(IDX_NOTICE_CONTROL, 8'hFF);
        rd(IDX_NOTICE_CONTROL, 32'h0000003F);
        wr(16'h4100, 8'h5A);
        rd(16'h4100, 32'h00000000);
        wr(IDX_TIMER_A_HIGH, 8'hA5);
        rd(IDX_TIMER_A_LOW, 32'h000000D0);
        rd(IDX_TIMER_A_HIGH, 32'h000000A5);
        wr(IDX_NOTICE_CONTROL, 8'h14);
        rd(IDX_NOTICE_STATUS, 32'h00000010);
        $display("register test done");
    endtask

    // Notice input ignored while disabled
    task automatic test_disabled();
        @(posedge clk);
        failCmd <= 1'b1;
        wait_attach(1'b0, 30);
        chk_cnt(n, 30, 30, "attach held while disabled");
        chk_val(noticeDescriptors, 1'b0, "standard while disabled");
        failCmd <= 1'b0;
        $display("disabled test done");
    endtask

    // Timer A on the default pin
    task automatic test_timer_a();
        wr(IDX_TIMER_A_LOW, 8'h03);
        wr(IDX_TIMER_A_HIGH, 8'h00);
        wr(IDX_NOTICE_CONTROL, 8'h15);
        repeat (3) @(posedge clk);
        notice_cycle(3, "timer A expiry");
        $display("timer A test done");
    endtask

    // Timer B on pin code 10000; the default pin no longer triggers
    task automatic test_timer_b();
        wr(IDX_TIMER_A_LOW, 8'h00);
        wr(IDX_TIMER_A_HIGH, 8'h01);
        wr(IDX_TIMER_B_LOW, 8'h02);
        wr(IDX_TIMER_B_HIGH, 8'h00);
        wr(IDX_NOTICE_CONTROL, 8'h21);
        askString <= 1'b1;
        @(posedge clk);
        failCmd <= 1'b1;
        wait_attach(1'b0, 20);
        chk_cnt(n, 20, 20, "unselected pin ignored");
        failCmd <= 1'b0;
        pdIdx <= 5'h10;
        repeat (3) @(posedge clk);
        notice_cycle(2, "timer B expiry");
        $display("timer B test done");
    endtask

    initial begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 16'h0000;
        writedata = 32'h00000000;
        failCmd = 1'b0;
        askString = 1'b0;
        pdIdx = PIN_SEL_DEFAULT;
        err_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        test_regs();
        test_disabled();
        test_timer_a();
        test_timer_b();
        close_out();
    end
endmodule
`default_nettype wire

//--- testbench/pd_host_model.sv
// Model of the outside controller and host that face the notice sequencer
`timescale 1ns/1ns
`default_nettype none
module pd_host_model #(
    parameter int HOST_DELAY = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Commands from the bench
    input wire logic failCmd,
    input wire logic askString,
    // Internal device state seen by the host
    input wire logic portAttach,
    input wire logic noticeDescriptors,
    // Notice pin and host events
    output logic pdPin,
    output logic addressAssigned,
    output logic altStringRequested
);
    logic attachPrev_r;
    int cnt_r;

    // Failed negotiation is signalled by pulling the pin low
    assign pdPin = ~failCmd;

    // ****************************************
    // Host enumeration of the notice device
    // ****************************************
    // A fresh attach with notice descriptors leads to an address, and
    // optionally a mode string request two cycles after it
    always_ff @(posedge clk) begin
        attachPrev_r <= portAttach;
        addressAssigned <= 1'b0;
        altStringRequested <= 1'b0;
        if (rst) begin
            cnt_r <= 0;
        end else if (portAttach && !attachPrev_r && noticeDescriptors) begin
            cnt_r <= 1;
        end else if (cnt_r != 0) begin
            cnt_r <= (cnt_r == HOST_DELAY + 2) ? 0 : cnt_r + 1;
            addressAssigned <= (cnt_r == HOST_DELAY);
            altStringRequested <= askString && (cnt_r == HOST_DELAY + 2);
        end
    end
endmodule
`default_nettype wire

//--- verilog/altmode_failure_notice_sequencer.sv
// Top of the alternate-mode failure notice sequencer with register slave
// Functional notes
// [R1] A 5-bit field of the control register picks the notice input pin, 01010 by default.
// [R2] The notice input is active low; the outside controller pulls it low on a failed negotiation.
// [R3] Bit 0 of the control register enables the whole notice function.
// [R4] On a low notice input the internal device is first dropped off the hub port.
// [R5] After that drop it reattaches presenting notice-class (version 1.1) descriptors.
// [R6] The first detach timer starts when the host assigns the address, 20 s by default.
// [R7] Notice descriptors report the configured status as unspecified error 00b.
// [R8] A request for the mode string starts the second detach timer, 20 s by default.
// [R9] Expiry of either timer drops the internal device off the port again.
// [R10] After that drop the device reattaches with its standard descriptors.
// [R11] Each timer counts in 10 ms steps per unit of its programmed value.
// [R12] The first timer value resets to low byte D0h and high byte 07h, 2000 units.
// [R13] The first timer's high byte sits in its own register right after the low byte.
// [R14] The second timer value sits in low and high registers after the first timer's.
// [R15] While disabled, the notice input is ignored and the device stays standard.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module altmode_failure_notice_sequencer
    import notice_pkg::*;
#(
    parameter int TICK = TICK_CYCLES,
    parameter int HOLD = DETACH_HOLD_CYCLES,
    parameter int PIN_COUNT = NOTICE_PIN_COUNT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [15:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // General-purpose pins
    input wire logic [PIN_COUNT-1:0] pinIn,
    // Host events on the internal device
    input wire logic addressAssigned,
    input wire logic altStringRequested,
    // Internal device control
    output logic portAttach,
    output logic noticeDescriptors,
    output logic [1:0] configuredStatus
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] timerA;
        logic [15:0] timerB;
        seq_state_t state;
        logic [HOLD_W-1:0] hold;
        logic prevLevel;
        logic waitReq;
        logic [31:0] rdata;
        logic attach;
        logic notice;
        logic [1:0] cfg;
    } top_state_t;

    top_state_t s_r;
    top_state_t s_nxt;

    logic noticeLevel;
    logic runA;
    logic runB;
    logic expA;
    logic expB;
    logic startA;
    logic startB;
    logic clearTimers;
    logic enabled;
    logic trigger;
    logic holdDone;
    logic [7:0] statusByte;

    // ****************************************
    // Input selection and timers
    // ****************************************
    pin_selector #(
        .PIN_COUNT(PIN_COUNT)
    ) u_sel (
        .clk(clk),
        .rst(rst),
        .pinIn(pinIn),
        .select(s_r.ctrl[CTRL_SEL_MSB:CTRL_SEL_LSB]), // R1
        .level(noticeLevel)
    );

    detach_timer #(
        .TICK(TICK)
    ) u_timer_a (
        .clk(clk),
        .rst(rst),
        .start(startA),
        .clear(clearTimers),
        .limit(s_r.timerA),
        .running(runA),
        .expired(expA)
    );

    detach_timer #(
        .TICK(TICK)
    ) u_timer_b (
        .clk(clk),
        .rst(rst),
        .start(startB),
        .clear(clearTimers),
        .limit(s_r.timerB),
        .running(runB),
        .expired(expB)
    );

    assign enabled = s_r.ctrl[CTRL_EN_BIT]; // R3
    // Edge, not level, so a pin held low does not loop the sequence
    assign trigger = s_r.prevLevel && !noticeLevel; // R2
    assign holdDone = (s_r.hold == HOLD_W'(HOLD - 1));
    assign startA = addressAssigned && s_r.state == ST_NOTICE; // R6
    assign startB = altStringRequested && s_r.state == ST_NOTICE; // R8
    assign clearTimers = (s_r.state != ST_NOTICE);

    always_comb begin
        statusByte = '0;
        statusByte[STAT_STATE_LSB +: 2] = s_r.state;
        statusByte[STAT_TIMER_A_BIT] = runA;
        statusByte[STAT_TIMER_B_BIT] = runB;
        statusByte[STAT_PIN_BIT] = noticeLevel;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.prevLevel = noticeLevel;

        // Bus slave: answer one cycle after the request is seen
        if (!s_r.waitReq) begin
            s_nxt.waitReq = 1'b1;
            if (write) begin
                if (address == IDX_NOTICE_CONTROL) begin
                    s_nxt.ctrl = writedata[7:0] & CTRL_WRITE_MASK;
                end else if (address == IDX_TIMER_A_LOW) begin
                    s_nxt.timerA[7:0] = writedata[7:0];
                end else if (address == IDX_TIMER_A_HIGH) begin
                    s_nxt.timerA[15:8] = writedata[7:0]; // R13
                end else if (address == IDX_TIMER_B_LOW) begin
                    s_nxt.timerB[7:0] = writedata[7:0]; // R14
                end else if (address == IDX_TIMER_B_HIGH) begin
                    s_nxt.timerB[15:8] = writedata[7:0]; // R14
                end
            end
        end else if (read || write) begin
            s_nxt.waitReq = 1'b0;
            s_nxt.rdata = '0;
            if (read) begin
                if (address == IDX_NOTICE_CONTROL) begin
                    s_nxt.rdata[7:0] = s_r.ctrl;
                end else if (address == IDX_NOTICE_STATUS) begin
                    s_nxt.rdata[7:0] = statusByte;
                end else if (address == IDX_TIMER_A_LOW) begin
                    s_nxt.rdata[7:0] = s_r.timerA[7:0];
                end else if (address == IDX_TIMER_A_HIGH) begin
                    s_nxt.rdata[7:0] = s_r.timerA[15:8];
                end else if (address == IDX_TIMER_B_LOW) begin
                    s_nxt.rdata[7:0] = s_r.timerB[7:0];
                end else if (address == IDX_TIMER_B_HIGH) begin
                    s_nxt.rdata[7:0] = s_r.timerB[15:8];
                end
            end
        end

        // Sequencer
        case (s_r.state)
            ST_NORMAL: begin
                s_nxt.hold = '0;
                if (enabled && trigger) begin // R15
                    s_nxt.state = ST_DROP_IN; // R4
                end
            end
            ST_DROP_IN: begin
                s_nxt.hold = s_r.hold + HOLD_W'(1);
                if (holdDone) begin
                    s_nxt.hold = '0;
                    s_nxt.state = ST_NOTICE; // R5
                end
            end
            ST_NOTICE: begin
                // Disabling mid-notice also restores the standard device
                if (expA || expB || !enabled) begin
                    s_nxt.state = ST_DROP_OUT; // R9
                end
            end
            ST_DROP_OUT: begin
                s_nxt.hold = s_r.hold + HOLD_W'(1);
                if (holdDone) begin
                    s_nxt.hold = '0;
                    s_nxt.state = ST_NORMAL; // R10
                end
            end
            default: begin
                s_nxt.state = ST_NORMAL;
            end
        endcase

        // Outputs follow the next state so they stay flop driven
        s_nxt.attach = (s_nxt.state == ST_NORMAL) ||
                       (s_nxt.state == ST_NOTICE);
        s_nxt.notice = (s_nxt.state == ST_NOTICE);
        s_nxt.cfg = CFG_UNSPECIFIED; // R7
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r.ctrl <= CTRL_RESET; // R1
            s_r.timerA <= {TIMER_HIGH_RESET, TIMER_LOW_RESET}; // R12
            s_r.timerB <= {TIMER_HIGH_RESET, TIMER_LOW_RESET};
            s_r.state <= ST_NORMAL;
            s_r.hold <= '0;
            s_r.prevLevel <= 1'b1;
            s_r.waitReq <= 1'b1;
            s_r.rdata <= '0;
            s_r.attach <= 1'b1;
            s_r.notice <= 1'b0;
            s_r.cfg <= CFG_UNSPECIFIED;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign readdata = s_r.rdata;
    assign waitrequest = s_r.waitReq;
    assign portAttach = s_r.attach;
    assign noticeDescriptors = s_r.notice;
    assign configuredStatus = s_r.cfg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_dropped;
        !portAttach && !noticeDescriptors;
    endsequence

    sequence s_noticeUp;
        portAttach && noticeDescriptors;
    endsequence

    property p_pinDefault;
        $past(rst) |-> s_r.ctrl[CTRL_SEL_MSB:CTRL_SEL_LSB] == PIN_SEL_DEFAULT;
    endproperty
    a_pinDefault: assert property (p_pinDefault) // R1
        else $error("pin select not default after reset");

    property p_disabledStays;
        (s_r.state == ST_NORMAL && !enabled) |=> portAttach && !noticeDescriptors;
    endproperty
    a_disabledStays: assert property (p_disabledStays) // R15
        else $error("disabled notice left standard mode");

    property p_detachFirst;
        (s_r.state == ST_NORMAL && enabled && trigger) |=> s_dropped;
    endproperty
    a_detachFirst: assert property (p_detachFirst) // R4
        else $error("no detach after notice input fell");

    property p_noticeAttach;
        (s_r.state == ST_DROP_IN && holdDone) |=> s_noticeUp;
    endproperty
    a_noticeAttach: assert property (p_noticeAttach) // R5
        else $error("notice descriptors not presented");

    property p_timerAStart;
        startA |=> runA;
    endproperty
    a_timerAStart: assert property (p_timerAStart) // R6
        else $error("first timer not running after address");

    property p_cfgStatus;
        noticeDescriptors |-> configuredStatus == 2'h0;
    endproperty
    a_cfgStatus: assert property (p_cfgStatus) // R7
        else $error("configured status not unspecified");

    property p_timerBStart;
        startB |=> runB;
    endproperty
    a_timerBStart: assert property (p_timerBStart) // R8
        else $error("second timer not running after string request");

    property p_expiryDetach;
        (s_r.state == ST_NOTICE && (expA || expB)) |=> s_dropped;
    endproperty
    a_expiryDetach: assert property (p_expiryDetach) // R9
        else $error("no detach after timer expiry");

    property p_standardBack;
        s_dropped ##1 (s_r.state == ST_DROP_OUT && holdDone)
            |=> portAttach && !noticeDescriptors;
    endproperty
    a_standardBack: assert property (p_standardBack) // R10
        else $error("standard device not restored");

    property p_timerReset;
        $past(rst) |-> s_r.timerA == 16'h07D0;
    endproperty
    a_timerReset: assert property (p_timerReset) // R12
        else $error("first timer reset value wrong");

    property p_busAnswer;
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_busAnswer: assert property (p_busAnswer) // bus handshake, no numbered rule
        else $error("bus answer not one cycle long");

    property p_writeAHigh;
        write && !waitrequest && address == IDX_TIMER_A_HIGH
            |=> s_r.timerA[15:8] == $past(writedata[7:0]);
    endproperty
    a_writeAHigh: assert property (p_writeAHigh) // R13
        else $error("first timer high byte write lost");

    property p_writeBHigh;
        write && !waitrequest && address == IDX_TIMER_B_HIGH
            |=> s_r.timerB[15:8] == $past(writedata[7:0]);
    endproperty
    a_writeBHigh: assert property (p_writeBHigh) // R14
        else $error("second timer high byte write lost");

    property p_readALow;
        read && waitrequest && address == IDX_TIMER_A_LOW
            |=> readdata == {24'h000000, $past(s_r.timerA[7:0])};
    endproperty
    a_readALow: assert property (p_readALow) // R12
        else $error("first timer low byte read wrong");

    property p_timersCleared;
        s_r.state == ST_DROP_OUT |=> !runA && !runB;
    endproperty
    a_timersCleared: assert property (p_timersCleared) // R10
        else $error("timer still running after notice ended");

endmodule
`default_nettype wire

//--- verilog/detach_timer.sv
// Detach timer counting 10 ms units up to a programmed limit
`timescale 1ns/1ns
`default_nettype none
module detach_timer
    import notice_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic clear,
    input wire logic [15:0] limit,
    // Status
    output logic running,
    output logic expired
);
    typedef struct packed {
        logic running;
        logic expired;
        logic [PRESCALE_W-1:0] presc;
        logic [15:0] units;
    } tmr_state_t;

    tmr_state_t s_r;
    tmr_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.expired = 1'b0;
        if (clear) begin
            s_nxt.running = 1'b0;
        end else if (start && !s_r.running) begin
            s_nxt.running = 1'b1;
            s_nxt.presc = '0;
            s_nxt.units = '0;
        end else if (s_r.running) begin
            if (s_r.presc == PRESCALE_W'(TICK - 1)) begin // R11
                s_nxt.presc = '0;
                s_nxt.units = s_r.units + 16'h0001;
                // A zero limit still waits one whole unit
                if (s_r.units + 16'h0001 >= limit) begin
                    s_nxt.running = 1'b0;
                    s_nxt.expired = 1'b1;
                end
            end else begin
                s_nxt.presc = s_r.presc + PRESCALE_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign running = s_r.running;
    assign expired = s_r.expired;
endmodule
`default_nettype wire

//--- verilog/notice_pkg.sv
// Constants shared by the alternate-mode failure notice sequencer
package notice_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PRESCALE_W = 20;
    localparam int DETACH_HOLD_US = 50;
    localparam int DETACH_HOLD_CYCLES = DETACH_HOLD_US * 1000 / CLK_PERIOD_NS;
    localparam int HOLD_W = 12;

    // ****************************************
    // Register indexes (word address = index)
    // ****************************************
    localparam logic [15:0] IDX_TIMER_A_LOW = 16'h413C;
    localparam logic [15:0] IDX_TIMER_A_HIGH = 16'h413D;
    localparam logic [15:0] IDX_TIMER_B_LOW = 16'h413E;
    localparam logic [15:0] IDX_TIMER_B_HIGH = 16'h413F;
    localparam logic [15:0] IDX_NOTICE_CONTROL = 16'h4180;
    localparam logic [15:0] IDX_NOTICE_STATUS = 16'h4181;

    // ****************************************
    // Reset values and fields
    // ****************************************
    localparam logic [7:0] CTRL_RESET = 8'h14;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h3F;
    localparam logic [7:0] TIMER_LOW_RESET = 8'hD0;
    localparam logic [7:0] TIMER_HIGH_RESET = 8'h07;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SEL_LSB = 1;
    localparam int CTRL_SEL_MSB = 5;
    localparam logic [4:0] PIN_SEL_DEFAULT = 5'h0A;
    localparam logic [4:0] PIN_SEL_RESERVED = 5'h09;
    localparam int NOTICE_PIN_COUNT = 17;
    localparam logic [1:0] CFG_UNSPECIFIED = 2'h0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_TIMER_A_BIT = 2;
    localparam int STAT_TIMER_B_BIT = 3;
    localparam int STAT_PIN_BIT = 4;

    // ****************************************
    // Sequencer states, Gray along the path
    // ****************************************
    typedef enum logic [1:0] {
        ST_NORMAL = 2'h0,
        ST_DROP_IN = 2'h1,
        ST_NOTICE = 2'h3,
        ST_DROP_OUT = 2'h2
    } seq_state_t;

endpackage

//--- verilog/pin_selector.sv
// Selects the failure notice input among the general-purpose pins
`timescale 1ns/1ns
`default_nettype none
module pin_selector
    import notice_pkg::*;
#(
    parameter int PIN_COUNT = NOTICE_PIN_COUNT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins and choice
    input wire logic [PIN_COUNT-1:0] pinIn,
    input wire logic [4:0] select,
    // Selected level
    output logic level
);
    typedef struct packed {
        logic level;
    } sel_state_t;

    sel_state_t s_r;
    sel_state_t s_nxt;
    logic [PIN_COUNT-1:0] usable;

    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_pin
            // Reserved code reads as an idle (high) input
            assign usable[i] = (5'(i) != PIN_SEL_RESERVED);
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        s_nxt.level = 1'b1;
        if (32'(select) < PIN_COUNT && usable[select]) begin
            s_nxt.level = pinIn[select];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '{level: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level = s_r.level;
endmodule
`default_nettype wire
